// ---- verilog/i2c_seq_consts.svh ----
`ifndef I2C_SEQ_CONSTS_SVH
`define I2C_SEQ_CONSTS_SVH
// ****************************************
// special function register addresses
// ****************************************
`define SFR_TX_BUF     8'h9a
`define SFR_RX_BUF     8'h9b
`define SFR_MODE       8'he8
`define SFR_TARGET     8'he9
`define SFR_STATUS     8'hea
// ****************************************
// field positions and reset values
// ****************************************
`define MODE_EN_BIT    7
`define MODE_RATE_HI   6
`define MODE_RATE_LO   5
`define MODE_RCT_HI    4
`define MODE_RCT_LO    0
`define ST_BUSY_BIT    7
`define ST_NOACK_BIT   6
`define ST_RXPEND_BIT  5
`define ST_TXEMPTY_BIT 4
`define ST_FILL_HI     3
`define ST_FILL_LO     2
`define ST_ACCERR_BIT  1
`define ST_TXERR_BIT   0
`define DIR_BIT        0
`define SFR_RESET      8'h00
`define FILL_EMPTY     2'h0
`define FILL_HALF      2'h2
`define FILL_FULL      2'h3
// ****************************************
// sizes and timing
// ****************************************
`define DATA_FIFO_DEPTH 4
`define LAST_BIT        3'h7
`define QTR_BASE        8'h04
`define PH_DRIVE        2'h0
`define PH_RISE         2'h1
`define PH_SAMPLE       2'h2
`define PH_FALL         2'h3
`endif

// ---- verilog/i2c_seq_pkg.sv ----
`default_nettype none
package i2c_seq_pkg;
  typedef logic [7:0] sfr_byte_t;
  // gray codes along start, address, write, read, stop
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_START = 4'h1,
    S_ADDR  = 4'h3,
    S_AACK  = 4'h2,
    S_WBYTE = 4'h6,
    S_WACK  = 4'h7,
    S_RBYTE = 4'h5,
    S_RACK  = 4'h4,
    S_STOP  = 4'hc
  } seq_state_t;
endpackage
`default_nettype wire

// ---- verilog/byte_fifo.sv ----
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData,
  output logic      [CW-1:0]    count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [CW-1:0]    count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != CW'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign count    = count_q;
  assign push     = inValid && inReady && !flush;
  assign pop      = outValid && outReady && !flush;

  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n || flush)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= nextPtr(wrPtr_q);
      if (pop)
        rdPtr_q <= nextPtr(rdPtr_q);
      count_q <= count_q + CW'(push) - CW'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- verilog/quarter_tick.sv ----
`default_nettype none
`include "i2c_seq_consts.svh"
module quarter_tick (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  output logic            tick
);
  // a serial bit is four quarters: core / (16 * 2^rate) per bit
  logic [7:0] cnt_q;
  logic [7:0] reload;

  assign reload = (`QTR_BASE << rate) - 8'h01;
  assign tick   = run && (cnt_q == 8'h00);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt_q <= 8'h00;
    else if (!run || cnt_q == 8'h00)
      cnt_q <= reload;
    else
      cnt_q <= cnt_q - 8'h01;
  end
endmodule
`default_nettype wire

// ---- verilog/i2c_master_status_sequencer.sv ----
`default_nettype none
`include "i2c_seq_consts.svh"
module i2c_master_status_sequencer (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire i2c_seq_pkg::sfr_byte_t sfrAddr,
  input  wire logic                   sfrWr,
  input  wire logic                   sfrRd,
  input  wire i2c_seq_pkg::sfr_byte_t sfrWdata,
  output i2c_seq_pkg::sfr_byte_t      sfrRdata,
  input  wire logic                   sclIn,
  output logic                        sclOut,
  output logic                        sclOe,
  input  wire logic                   sdaIn,
  output logic                        sdaOut,
  output logic                        sdaOe
);
  import i2c_seq_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  seq_state_t state_q;
  logic [1:0] ph_q;
  sfr_byte_t  mode_q;
  sfr_byte_t  target_q;
  sfr_byte_t  active_q;
  sfr_byte_t  shift_q;
  sfr_byte_t  rdata_q;
  logic [2:0] bitCnt_q;
  logic [4:0] rxCnt_q;
  logic       sclOe_q, sdaOe_q, pinLow_q, sample_q, readDir_q, pending_q;
  logic       noAck_q, rxPend_q, txEmpty_q, accErr_q, txErr_q;
  logic [1:0] sclSync_q, sdaSync_q;
  logic       sclS, sdaS, tick, collide, launch, busy, bitEnd;
  logic       noAckEv, lastByte, outBit, stsWr, txWr, rxRd, restart;
  logic       txInReady, txOutValid, txOutReady, txFlush;
  logic       rxInValid, rxInReady, rxOutValid, rxOutReady;
  sfr_byte_t  txOutData, rxOutData, rxByte, status;
  logic [2:0] txCount, rxCount;

  function automatic logic wrHit(input sfr_byte_t a, input sfr_byte_t which);
    wrHit = (a == which);
  endfunction

  function automatic logic [1:0] fill(input logic [2:0] cnt, input logic notFull);
    if (cnt == 3'h0)
      fill = `FILL_EMPTY;
    else if (!notFull)
      fill = `FILL_FULL;
    else
      fill = `FILL_HALF;
  endfunction

  // ****************************************
  // bus decode
  // ****************************************
  assign collide  = sfrWr && sfrRd;
  assign launch   = sfrWr && !sfrRd && wrHit(sfrAddr, `SFR_TARGET)
                    && mode_q[`MODE_EN_BIT];
  assign stsWr    = sfrWr && !sfrRd && wrHit(sfrAddr, `SFR_STATUS);
  assign txWr     = sfrWr && !sfrRd && wrHit(sfrAddr, `SFR_TX_BUF);
  assign rxRd     = sfrRd && !sfrWr && wrHit(sfrAddr, `SFR_RX_BUF);
  assign busy     = (state_q != S_IDLE);
  assign bitEnd   = tick && (ph_q == `PH_FALL);
  assign lastByte = (rxCnt_q == mode_q[`MODE_RCT_HI:`MODE_RCT_LO]);
  assign rxByte   = {shift_q[6:0], sample_q};
  assign noAckEv  = bitEnd && sample_q && (state_q == S_AACK || state_q == S_WACK);
  // a waiting address takes over where the current transfer would end
  assign restart  = pending_q && (!busy || (bitEnd && (state_q == S_STOP
                    || (state_q == S_RACK && lastByte)
                    || ((state_q == S_AACK || state_q == S_WACK)
                        && (sample_q || (!readDir_q && !txOutValid))))));
  assign sclS     = sclSync_q[1];
  assign sdaS     = sdaSync_q[1];

  // ****************************************
  // data FIFOs and serial clock divider
  // ****************************************
  assign txOutReady = bitEnd && !sample_q && !readDir_q
                      && (state_q == S_AACK || state_q == S_WACK);
  assign txFlush    = noAckEv && !readDir_q;
  assign rxInValid  = bitEnd && state_q == S_RBYTE && bitCnt_q == `LAST_BIT;
  assign rxOutReady = rxRd;

  byte_fifo #(.WIDTH(8), .DEPTH(`DATA_FIFO_DEPTH)) txFifo (
    .mclk(mclk), .rst_n(rst_n), .flush(txFlush),
    .inValid(txWr), .inReady(txInReady), .inData(sfrWdata),
    .outValid(txOutValid), .outReady(txOutReady), .outData(txOutData),
    .count(txCount)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(`DATA_FIFO_DEPTH)) rxFifo (
    .mclk(mclk), .rst_n(rst_n), .flush(1'b0),
    .inValid(rxInValid), .inReady(rxInReady), .inData(rxByte),
    .outValid(rxOutValid), .outReady(rxOutReady), .outData(rxOutData),
    .count(rxCount)
  );

  quarter_tick divider (
    .mclk(mclk), .rst_n(rst_n), .run(busy),
    .rate(mode_q[`MODE_RATE_HI:`MODE_RATE_LO]), .tick(tick)
  );

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
    end
    else
    begin
      sclSync_q <= {sclSync_q[0], sclIn};
      sdaSync_q <= {sdaSync_q[0], sdaIn};
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mode_q   <= `SFR_RESET;
      target_q <= `SFR_RESET;
    end
    else if (sfrWr && !sfrRd)
    begin
      if (wrHit(sfrAddr, `SFR_MODE))
        mode_q <= sfrWdata;
      if (wrHit(sfrAddr, `SFR_TARGET))
        target_q <= sfrWdata;
    end
  end

  // address on the wire; a rewrite while busy waits for the restart
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      active_q <= `SFR_RESET;
    else if (launch && !busy)
      active_q <= sfrWdata;
    else if (restart)
      active_q <= target_q;
  end

  // ****************************************
  // status flags, set wins over clear
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      noAck_q   <= 1'b0;
      rxPend_q  <= 1'b0;
      txEmpty_q <= 1'b0;
      accErr_q  <= 1'b0;
      txErr_q   <= 1'b0;
    end
    else
    begin
      noAck_q   <= noAckEv | (noAck_q & ~(stsWr & ~sfrWdata[`ST_NOACK_BIT]));
      rxPend_q  <= rxOutValid | (rxPend_q & ~(stsWr & ~sfrWdata[`ST_RXPEND_BIT]));
      txEmpty_q <= !txOutValid | (txEmpty_q & ~(stsWr & ~sfrWdata[`ST_TXEMPTY_BIT]));
      accErr_q  <= collide | (accErr_q & ~(stsWr & ~sfrWdata[`ST_ACCERR_BIT]));
      txErr_q   <= (txWr & ~txInReady)
                   | (txErr_q & ~(stsWr & ~sfrWdata[`ST_TXERR_BIT]));
    end
  end

  // ****************************************
  // read data
  // ****************************************
  assign status = {busy, noAck_q, rxPend_q, txEmpty_q,
                   readDir_q ? fill(rxCount, rxInReady) : fill(txCount, txInReady),
                   accErr_q, txErr_q};

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata_q <= `SFR_RESET;
    else if (sfrRd && !sfrWr)
    begin
      unique case (sfrAddr)
        `SFR_RX_BUF: rdata_q <= rxOutValid ? rxOutData : `SFR_RESET;
        `SFR_MODE:   rdata_q <= mode_q;
        `SFR_TARGET: rdata_q <= target_q;
        `SFR_STATUS: rdata_q <= status;
        default:     rdata_q <= `SFR_RESET;
      endcase
    end
  end

  // ****************************************
  // bus sequencer
  // ****************************************
  always_comb
  begin
    unique case (state_q)
      S_ADDR, S_WBYTE: outBit = shift_q[7];
      S_RACK:          outBit = lastByte;
      default:         outBit = 1'b1;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q   <= S_IDLE;
      ph_q      <= `PH_DRIVE;
      shift_q   <= `SFR_RESET;
      bitCnt_q  <= 3'h0;
      rxCnt_q   <= 5'h00;
      sclOe_q   <= 1'b0;
      sdaOe_q   <= 1'b0;
      sample_q  <= 1'b0;
      readDir_q <= 1'b0;
      pending_q <= 1'b0;
    end
    else
    begin
      if ((launch || pending_q) && !busy)
      begin
        state_q <= S_START;
        ph_q    <= `PH_DRIVE;
      end
      else if (tick)
      begin
        unique case (state_q)
          S_IDLE: ;
          S_START:
          begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              `PH_DRIVE:  sdaOe_q <= 1'b0;
              `PH_RISE:   sclOe_q <= 1'b0;
              `PH_SAMPLE: sdaOe_q <= 1'b1;
              `PH_FALL:
              begin
                sclOe_q   <= 1'b1;
                shift_q   <= active_q;
                readDir_q <= active_q[`DIR_BIT];
                bitCnt_q  <= 3'h0;
                rxCnt_q   <= 5'h00;
                state_q   <= S_ADDR;
              end
            endcase
          end
          S_STOP:
          begin
            ph_q <= ph_q + 2'h1;
            unique case (ph_q)
              `PH_DRIVE:  sdaOe_q <= 1'b1;
              `PH_RISE:   sclOe_q <= 1'b0;
              `PH_SAMPLE: sdaOe_q <= 1'b0;
              `PH_FALL:   state_q <= pending_q ? S_START : S_IDLE;
            endcase
          end
          S_ADDR, S_AACK, S_WBYTE, S_WACK, S_RBYTE, S_RACK:
          begin
            unique case (ph_q)
              `PH_DRIVE:
              begin
                sclOe_q <= 1'b1;
                sdaOe_q <= ~outBit;
                ph_q    <= `PH_RISE;
              end
              `PH_RISE:
              begin
                sclOe_q <= 1'b0;
                ph_q    <= `PH_SAMPLE;
              end
              `PH_SAMPLE:
              begin
                if (sclS)
                begin
                  sample_q <= sdaS;
                  ph_q     <= `PH_FALL;
                end
              end
              `PH_FALL:
              begin
                sclOe_q <= 1'b1;
                if (state_q != S_RBYTE || bitCnt_q != `LAST_BIT || rxInReady)
                  ph_q <= `PH_DRIVE;
                unique case (state_q)
                  S_ADDR, S_WBYTE:
                  begin
                    shift_q  <= {shift_q[6:0], 1'b0};
                    bitCnt_q <= bitCnt_q + 3'h1;
                    if (bitCnt_q == `LAST_BIT)
                      state_q <= (state_q == S_ADDR) ? S_AACK : S_WACK;
                  end
                  S_RBYTE:
                  begin
                    if (bitCnt_q != `LAST_BIT)
                    begin
                      shift_q  <= rxByte;
                      bitCnt_q <= bitCnt_q + 3'h1;
                    end
                    else if (rxInReady)
                    begin
                      bitCnt_q <= 3'h0;
                      state_q  <= S_RACK;
                    end
                  end
                  S_RACK:
                  begin
                    rxCnt_q <= rxCnt_q + 5'h01;
                    state_q <= lastByte ? (pending_q ? S_START : S_STOP) : S_RBYTE;
                  end
                  default:
                  begin
                    if (sample_q || (!readDir_q && !txOutValid))
                      state_q <= pending_q ? S_START : S_STOP;
                    else if (readDir_q)
                      state_q <= S_RBYTE;
                    else
                    begin
                      shift_q <= txOutData;
                      state_q <= S_WBYTE;
                    end
                  end
                endcase
              end
            endcase
          end
          default: state_q <= S_IDLE;
        endcase
      end
      if (restart)
        pending_q <= 1'b0;
      if (launch && busy)
        pending_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    pinLow_q <= 1'b0;
  end

  assign sclOe    = sclOe_q;
  assign sdaOe    = sdaOe_q;
  assign sclOut   = pinLow_q;
  assign sdaOut   = pinLow_q;
  assign sfrRdata = rdata_q;

  // ****************************************
  // checks
  // ****************************************
  sequence sNack;
    noAckEv;
  endsequence

  property pNackStops;
    @(posedge mclk) disable iff (!rst_n)
      sNack |=> noAck_q && (state_q == S_STOP || state_q == S_START);
  endproperty

  a_nack_stops: assert property (pNackStops)
    else $error("missing ack did not stop the transfer");

  a_launch_busy: assert property (@(posedge mclk) disable iff (!rst_n)
    launch && !busy |=> state_q == S_START && ph_q == `PH_DRIVE && active_q == $past(sfrWdata))
    else $error("target write did not launch");

  a_busy_status: assert property (@(posedge mclk) disable iff (!rst_n)
    sfrRd && !sfrWr && sfrAddr == `SFR_STATUS |=> sfrRdata[`ST_BUSY_BIT] == $past(busy))
    else $error("busy bit does not follow sequencer");

  a_rx_pending: assert property (@(posedge mclk) disable iff (!rst_n)
    rxCount != 3'h0 |=> rxPend_q)
    else $error("receive pending lost");

  a_tx_empty: assert property (@(posedge mclk) disable iff (!rst_n)
    txCount == 3'h0 |=> txEmpty_q)
    else $error("transmit empty lost");

  a_fill_full: assert property (@(posedge mclk) disable iff (!rst_n)
    sfrRd && !sfrWr && sfrAddr == `SFR_STATUS && !readDir_q && txCount == 3'h4
    |=> sfrRdata[`ST_FILL_HI:`ST_FILL_LO] == `FILL_FULL)
    else $error("fill state not full");

  a_collision_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    collide |=> accErr_q [*2] or (accErr_q ##1 $past(stsWr)))
    else $error("collision not flagged");

  a_overfill_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    txWr && !txInReady
    |=> txErr_q && (txCount == 3'h4 - 3'($past(txOutReady)) || $past(txFlush)))
    else $error("overfill not flagged");

  a_clear_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    stsWr && !sfrWdata[`ST_TXERR_BIT] |=> !txErr_q)
    else $error("overfill flag not cleared");

  a_read_ack: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == S_RACK && ph_q == `PH_SAMPLE && !lastByte |-> sdaOe_q && !sclOe_q)
    else $error("master ack not driven");

  a_read_nack: assert property (@(posedge mclk) disable iff (!rst_n)
    state_q == S_RACK && ph_q == `PH_SAMPLE && lastByte |-> !sdaOe_q)
    else $error("last byte not nacked");

  a_repeat_start: assert property (@(posedge mclk) disable iff (!rst_n)
    pending_q && bitEnd && !sample_q && !readDir_q && !txOutValid
    && (state_q == S_AACK || state_q == S_WACK) |=> state_q == S_START)
    else $error("stop issued despite pending address");
endmodule
`default_nettype wire

// ---- sim/i2c_slave_model.sv ----
`default_nettype none
module i2c_slave_model #(
  parameter logic [7:0] FIRST = 8'hc5
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ackEn,
  output logic            sdaPull,
  output logic [7:0]      addrByte,
  output logic [7:0]      lastByte,
  output int              byteCnt,
  output int              startCnt,
  output int              stopCnt,
  output int              mAcks,
  output int              mNacks
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [7:0] txVal;
  int         bits;
  logic       inAddr;
  logic       rdMode;
  logic       live;
  logic       lastAck;
  initial
  begin
    {sdaPull, live, rdMode, inAddr, lastAck} = '0;
    {addrByte, lastByte, sh, txVal} = '0;
    {byteCnt, startCnt, stopCnt, mAcks, mNacks, bits} = '0;
  end
  // ****************************************
  // start and stop conditions
  // ****************************************
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      startCnt++;
      bits = 0;
      inAddr = 1'b1;
      rdMode = 1'b0;
      live = 1'b1;
      byteCnt = 0;
      txVal = FIRST;
    end
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      stopCnt++;
      live = 1'b0;
      sdaPull = 1'b0;
    end
  // ****************************************
  // bit shifting and acknowledge
  // ****************************************
  always @(posedge scl)
    if (live)
    begin
      if (bits < 8)
        sh = {sh[6:0], sda};
      else if (rdMode && !inAddr)
      begin
        lastAck = sda;
        if (sda)
          mNacks++;
        else
          mAcks++;
      end
      bits++;
    end
  // data and ack change only while scl is low
  always @(negedge scl)
    if (live)
    begin
      if (bits == 8)
      begin
        if (inAddr || !rdMode)
        begin
          byteCnt++;
          lastByte = sh;
          if (inAddr)
            addrByte = sh;
          if (inAddr)
            rdMode = sh[0];
          sdaPull = ackEn;
        end
        else
          sdaPull = 1'b0;
      end
      else if (bits == 9)
      begin
        bits = 0;
        if (rdMode && (inAddr ? ackEn : !lastAck))
        begin
          if (!inAddr)
            txVal++;
          sdaPull = !txVal[7];
        end
        else
          sdaPull = 1'b0;
        inAddr = 1'b0;
      end
      else if (rdMode && !inAddr && bits > 0)
        sdaPull = !txVal[7-bits];
    end
endmodule
`default_nettype wire

// ---- sim/tb_i2c_master_status_sequencer.sv ----
`default_nettype none
`include "i2c_seq_consts.svh"
module tb_i2c_master_status_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_seq_pkg::*;
  typedef struct packed {logic [7:0] a; logic w; logic [7:0] d;} row_t;
  logic      mclk = 1'b0;
  logic      rst_n = 1'b0;
  sfr_byte_t sfrAddr = '0;
  logic      sfrWr = 1'b0;
  logic      sfrRd = 1'b0;
  sfr_byte_t sfrWdata = '0;
  sfr_byte_t sfrRdata;
  logic      sclOut, sclOe, sdaOut, sdaOe, sdaPull, sclLine, sdaLine;
  logic      ackEn = 1'b1;
  logic [7:0] addrByte, lastByte;
  int        byteCnt, startCnt, stopCnt, mAcks, mNacks;
  int        errCount = 0;
  int        samplesChecked = 0;
  int        cycles = 0;
  int        s0, p0;
  time       t0;
  sfr_byte_t s;
  row_t      rows [20] = '{
    '{`SFR_STATUS, 0, 8'h10}, '{`SFR_MODE, 0, 8'h00}, '{`SFR_TARGET, 0, 8'h00},
    '{`SFR_STATUS, 1, 8'hff}, '{`SFR_STATUS, 0, 8'h10}, '{`SFR_TX_BUF, 1, 8'h11},
    '{`SFR_STATUS, 0, 8'h18}, '{`SFR_STATUS, 1, 8'h00}, '{`SFR_STATUS, 0, 8'h08},
    '{`SFR_TX_BUF, 1, 8'h22}, '{`SFR_TX_BUF, 1, 8'h33}, '{`SFR_TX_BUF, 1, 8'h44},
    '{`SFR_STATUS, 0, 8'h0c}, '{`SFR_TX_BUF, 1, 8'h55}, '{`SFR_STATUS, 0, 8'h0d},
    '{`SFR_STATUS, 1, 8'h00}, '{8'h55, 0, 8'h00}, '{`SFR_STATUS, 0, 8'h0c},
    '{`SFR_MODE, 1, 8'ha0}, '{`SFR_MODE, 0, 8'ha0}};
  // open-drain lines with pull-ups
  assign sclLine = !sclOe;
  assign sdaLine = !(sdaOe || sdaPull);
  always #2.5 mclk = ~mclk;
  i2c_master_status_sequencer i_i2c_master_status_sequencer (
    .mclk(mclk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .sclIn(sclLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
  i2c_slave_model i_i2c_slave_model (
    .scl(sclLine), .sda(sdaLine), .ackEn(ackEn), .sdaPull(sdaPull), .addrByte(addrByte),
    .lastByte(lastByte), .byteCnt(byteCnt), .startCnt(startCnt), .stopCnt(stopCnt),
    .mAcks(mAcks), .mNacks(mNacks));
  // ****************************************
  // helpers
  // ****************************************
  task automatic wrapUp;
    $display("checks %0d errors %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
    @(negedge mclk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'b1;
    @(negedge mclk);
    sfrWr = 1'b0;
  endtask
  task automatic rd(input sfr_byte_t a, output sfr_byte_t d);
    @(negedge mclk);
    sfrAddr = a;
    sfrRd = 1'b1;
    @(negedge mclk);
    sfrRd = 1'b0;
    d = sfrRdata;
  endtask
  task automatic rdChk(input sfr_byte_t a, input sfr_byte_t e, input string nm);
    sfr_byte_t v;
    rd(a, v);
    check(nm, 16'(v), 16'(e));
  endtask
  task automatic waitIdle;
    sfr_byte_t v;
    v = 8'h80;
    for (int n = 0; n < 4000 && v[7] !== 1'b0; n++)
      rd(`SFR_STATUS, v);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errCount++;
      wrapUp;
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (6) @(negedge mclk);
    check("reset rdata", 16'(sfrRdata), 16'h0000);
    check("reset pins", 16'({sclOut, sdaOut, sclOe, sdaOe}), 16'h0000);
    rst_n = 1'b1;
    foreach (rows[i])
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
        rdChk(rows[i].a, rows[i].d, "table");
    // write of four queued bytes at rate 1
    wr(`SFR_TARGET, 8'ha0);
    @(posedge sclLine);
    t0 = $time;
    @(posedge sclLine);
    check("bit period", 16'(($time - t0) / 5), 16'd32);
    rd(`SFR_STATUS, s);
    check("busy", 16'(s[7]), 16'd1);
    check("pin drive", 16'({sclOut, sdaOut}), 16'h0000);
    waitIdle;
    check("address", 16'(addrByte), 16'h00a0);
    check("last data", 16'(lastByte), 16'h0044);
    check("bytes", 16'(byteCnt), 16'd5);
    rdChk(`SFR_STATUS, 8'h10, "after write");
    // read of count plus one bytes
    wr(`SFR_MODE, 8'h82);
    wr(`SFR_TARGET, 8'ha1);
    waitIdle;
    check("master acks", 16'(mAcks), 16'd2);
    check("master nacks", 16'(mNacks), 16'd1);
    rdChk(`SFR_STATUS, 8'h38, "rx status");
    for (int k = 0; k < 3; k++)
      rdChk(`SFR_RX_BUF, 8'(8'hc5 + k), "rx byte");
    // slave refuses the address
    wr(`SFR_STATUS, 8'h00);
    ackEn = 1'b0;
    wr(`SFR_TX_BUF, 8'h66);
    wr(`SFR_MODE, 8'h80);
    wr(`SFR_TARGET, 8'ha0);
    waitIdle;
    rdChk(`SFR_STATUS, 8'h50, "nack status");
    check("nack bytes", 16'(byteCnt), 16'd1);
    // target rewritten mid-transfer
    ackEn = 1'b1;
    s0 = startCnt;
    p0 = stopCnt;
    wr(`SFR_TX_BUF, 8'h77);
    wr(`SFR_TARGET, 8'ha0);
    wr(`SFR_TARGET, 8'ha2);
    waitIdle;
    check("starts", 16'(startCnt - s0), 16'd2);
    check("stops", 16'(stopCnt - p0), 16'd1);
    check("new target", 16'(addrByte), 16'h00a2);
    // write and read strobes together
    wr(`SFR_STATUS, 8'h00);
    @(negedge mclk);
    sfrAddr = `SFR_TX_BUF;
    sfrWr = 1'b1;
    sfrRd = 1'b1;
    @(negedge mclk);
    sfrWr = 1'b0;
    sfrRd = 1'b0;
    rdChk(`SFR_STATUS, 8'h12, "collision");
    wrapUp;
  end
endmodule
`default_nettype wire
